/* File: design/pin_mux_pkg.sv */
// Package for the port pin function multiplexer: widths, pin indices, timing counts, carriers.
// Assumes a single 20 MHz system clock.
package pin_mux_pkg;
  localparam int          BYTE_W         = 8;
  localparam int          CLK_HZ         = 20_000_000;
  localparam int          POR_EXP        = 17;
  localparam int          SETTLE_EXP     = 18;
  localparam int          POR_CYCLES     = 2 ** POR_EXP;
  localparam int          SETTLE_CYCLES  = 2 ** SETTLE_EXP;
  localparam int          CNT_W          = SETTLE_EXP + 1;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [7:0]  BYTE_ONES      = 8'hff;
  localparam logic [7:0]  UPPER_ADDR_RST = 8'h00;
  localparam int          P3_ALE         = 0;
  localparam int          P3_RD          = 1;
  localparam int          P3_WR          = 2;
  localparam int          P4_SCKA        = 4;
  localparam int          P4_TXA         = 5;
  localparam int          P4_TXX         = 6;
  localparam int          P4_SCKX        = 7;
  localparam int          P5_RXX         = 0;
  localparam int          P5_IRQ_LO      = 1;
  localparam int          P5_TRIG        = 5;
  localparam int          P5_TIMER       = 6;

  // One port's register-side view: data, direction (1 = output), pull-up enable
  typedef struct packed {
    logic [7:0] dat;
    logic [7:0] dir;
    logic [7:0] pull;
  } port_ctrl_t;

  // One port's pin-side view
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } pin_drive_t;

  // Serial unit pin requests
  typedef struct packed {
    logic sck_en;
    logic sck_o;
    logic tx_en;
    logic tx_o;
  } serial_req_t;

  typedef enum logic [1:0] {
    ST_POR    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } pwr_state_t;
endpackage : pin_mux_pkg

/* File: design/port_pin_function_mux.sv */
// Port pin function multiplexer: routes each pin to general I/O or its alternate function.
// Assumes port registers, bus controller and serial units sit outside and run on MCLK.
//
// Contract
// - Port zero: general I/O with pull-up, or low bus byte when bus enabled.
// - Port one: general I/O with pull-up, or high bus byte when bus enabled.
// - Port two bit: I/O when control bit is 1, upper address when 0 and bus enabled.
// - Port three bit0 drives address latch enable when bus enabled.
// - Port three bit1 drives read strobe when bus enabled.
// - Port three bit2 drives write strobe only with bus and strobe output enabled.
// - Write strobe covers low byte in 16-bit access, whole byte in 8-bit.
// - Serial A clock pin is bidirectional clock when unit enables it.
// - Serial A data pin drives serial data when unit enables it.
// - Extended serial data pin drives data when interface enables it.
// - Extended serial clock pin is bidirectional clock when enabled.
// - Extended serial input stays I/O and feeds receiver; software sets input.
// - Port five bits1-4 feed interrupts four to seven; stay I/O.
// - Port five bit5 feeds converter trigger; stays I/O.
// - Port six pin goes analog when enable register selects analog.
// - Port five bit6 feeds timer zero event; stays I/O.
// - Ports zero and one float while reset is low during settling.
// - Power-on reset lasts 2^17 clock periods before internal reset releases.
// - Settling lasts 2^18 periods; ports zero/one follow reset state throughout.
module port_pin_function_mux
  import pin_mux_pkg::*;
#(
  parameter int POR_LEN    = POR_CYCLES,
  parameter int SETTLE_LEN = SETTLE_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        RST_PIN,
  input  wire logic        EXT_BUS_EN,
  input  wire logic        WR_PIN_EN,
  input  wire logic        BUS_WIDE,
  input  wire logic [7:0]  UPPER_ADDR_OUTPUT_CTRL,
  input  wire logic [7:0]  ANALOG_SEL,
  input  wire logic [15:0] BUS_AD_O,
  input  wire logic        BUS_AD_OE,
  input  wire logic [7:0]  UPPER_ADDRESS_LINES,
  input  wire logic        BUS_ALE,
  input  wire logic        BUS_RD,
  input  wire logic        BUS_WR,
  input  wire serial_req_t SERIAL_A_REQ,
  input  wire serial_req_t EXT_SERIAL_REQ,
  input  wire port_ctrl_t  PORT0_CTRL,
  input  wire port_ctrl_t  PORT1_CTRL,
  input  wire port_ctrl_t  PORT2_CTRL,
  input  wire port_ctrl_t  PORT3_CTRL,
  input  wire port_ctrl_t  PORT4_CTRL,
  input  wire port_ctrl_t  PORT5_CTRL,
  input  wire port_ctrl_t  PORT6_CTRL,
  input  wire logic [7:0]  PORT0_IN,
  input  wire logic [7:0]  PORT1_IN,
  input  wire logic [7:0]  PORT4_IN,
  input  wire logic [7:0]  PORT5_IN,
  input  wire logic [7:0]  PORT6_IN,
  output pin_drive_t       PORT0_PINS,
  output pin_drive_t       PORT1_PINS,
  output pin_drive_t       PORT2_PINS,
  output pin_drive_t       PORT3_PINS,
  output pin_drive_t       PORT4_PINS,
  output pin_drive_t       PORT5_PINS,
  output pin_drive_t       PORT6_PINS,
  output logic [7:0]       ANALOG_CONNECT,
  output logic [7:0]       PORT6_DIGITAL_IN,
  output logic [15:0]      BUS_AD_I,
  output logic             WR_LOW_BYTE_STROBE,
  output logic             WR_BYTE_STROBE,
  output logic             SERIAL_A_CLOCK_IN,
  output logic             EXT_SERIAL_CLOCK_IN,
  output logic             EXT_SERIAL_RX,
  output logic [3:0]       EXT_IRQ_INPUTS_HI,
  output logic             CONVERTER_TRIGGER_IN,
  output logic             TIMER_EVENT_IN,
  output logic             INTERNAL_RESET_N,
  output logic             SETTLING
);

  // ----------------------------------------------------------------
  // Power-on sequence
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] POR_END    = CNT_W'(POR_LEN - 1);
  localparam logic [CNT_W-1:0] SETTLE_END = CNT_W'(SETTLE_LEN - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = '0;
  localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);

  pwr_state_t       pwr_r;
  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      pwr_r <= ST_POR;
      cnt_r <= CNT_ZERO;
    end else begin
      case (pwr_r)
        ST_POR: begin
          if (cnt_r == POR_END) begin
            pwr_r <= ST_SETTLE;
          end
          cnt_r <= cnt_r + CNT_ONE;
        end
        ST_SETTLE: begin
          if (cnt_r == SETTLE_END) begin
            pwr_r <= ST_RUN;
            cnt_r <= CNT_ZERO;
          end else begin
            cnt_r <= cnt_r + CNT_ONE;
          end
        end
        ST_RUN: begin
          cnt_r <= CNT_ZERO;
        end
        default: begin
          pwr_r <= ST_POR;
          cnt_r <= CNT_ZERO;
        end
      endcase
    end
  end

  logic settling;
  assign settling         = (pwr_r != ST_RUN);
  assign SETTLING         = settling;
  assign INTERNAL_RESET_N = (pwr_r != ST_POR);

  // ----------------------------------------------------------------
  // Port zero and one: general I/O or multiplexed address/data
  // ----------------------------------------------------------------
  pin_drive_t p0, p1;

  always_comb begin
    p0.o  = PORT0_CTRL.dat;
    p0.oe = PORT0_CTRL.dir;
    p0.pu = PORT0_CTRL.pull;
    p1.o  = PORT1_CTRL.dat;
    p1.oe = PORT1_CTRL.dir;
    p1.pu = PORT1_CTRL.pull;
    if (EXT_BUS_EN) begin
      p0.o  = BUS_AD_O[7:0];
      p0.oe = BUS_AD_OE ? BYTE_ONES : BYTE_ZERO;
      p0.pu = BYTE_ZERO;
      p1.o  = BUS_AD_O[15:8];
      p1.oe = BUS_AD_OE ? BYTE_ONES : BYTE_ZERO;
      p1.pu = BYTE_ZERO;
    end
    // Reset held low while settling floats both ports; high leaves them as they fall
    if (settling && !RST_PIN) begin
      p0.oe = BYTE_ZERO;
      p0.pu = BYTE_ZERO;
      p1.oe = BYTE_ZERO;
      p1.pu = BYTE_ZERO;
    end
  end

  assign PORT0_PINS = p0;
  assign PORT1_PINS = p1;
  assign BUS_AD_I   = {PORT1_IN, PORT0_IN};

  // ----------------------------------------------------------------
  // Port two: per-bit upper address or I/O
  // ----------------------------------------------------------------
  pin_drive_t p2;

  always_comb begin
    for (int i = 0; i < BYTE_W; i++) begin
      if (EXT_BUS_EN && !UPPER_ADDR_OUTPUT_CTRL[i]) begin
        p2.o[i]  = UPPER_ADDRESS_LINES[i];
        p2.oe[i] = 1'b1;
        p2.pu[i] = 1'b0;
      end else begin
        p2.o[i]  = PORT2_CTRL.dat[i];
        p2.oe[i] = PORT2_CTRL.dir[i];
        p2.pu[i] = PORT2_CTRL.pull[i];
      end
    end
  end

  assign PORT2_PINS = p2;

  // ----------------------------------------------------------------
  // Port three: bus strobes
  // ----------------------------------------------------------------
  pin_drive_t p3;
  logic       wr_active;

  assign wr_active = EXT_BUS_EN && WR_PIN_EN;

  always_comb begin
    p3.o  = PORT3_CTRL.dat;
    p3.oe = PORT3_CTRL.dir;
    p3.pu = PORT3_CTRL.pull;
    if (EXT_BUS_EN) begin
      p3.o[P3_ALE]  = BUS_ALE;
      p3.oe[P3_ALE] = 1'b1;
      p3.pu[P3_ALE] = 1'b0;
      p3.o[P3_RD]   = BUS_RD;
      p3.oe[P3_RD]  = 1'b1;
      p3.pu[P3_RD]  = 1'b0;
    end
    if (wr_active) begin
      p3.o[P3_WR]  = BUS_WR;
      p3.oe[P3_WR] = 1'b1;
      p3.pu[P3_WR] = 1'b0;
    end
  end

  assign PORT3_PINS = p3;

  // Strobe qualification by access width
  assign WR_LOW_BYTE_STROBE = wr_active && BUS_WIDE && BUS_WR;
  assign WR_BYTE_STROBE     = wr_active && !BUS_WIDE && BUS_WR;

  // ----------------------------------------------------------------
  // Port four: serial units
  // ----------------------------------------------------------------
  pin_drive_t p4;

  always_comb begin
    p4.o  = PORT4_CTRL.dat;
    p4.oe = PORT4_CTRL.dir;
    p4.pu = BYTE_ZERO;
    if (SERIAL_A_REQ.sck_en) begin
      p4.o[P4_SCKA]  = SERIAL_A_REQ.sck_o;
      p4.oe[P4_SCKA] = 1'b1;
    end
    if (SERIAL_A_REQ.tx_en) begin
      p4.o[P4_TXA]  = SERIAL_A_REQ.tx_o;
      p4.oe[P4_TXA] = 1'b1;
    end
    if (EXT_SERIAL_REQ.tx_en) begin
      p4.o[P4_TXX]  = EXT_SERIAL_REQ.tx_o;
      p4.oe[P4_TXX] = 1'b1;
    end
    if (EXT_SERIAL_REQ.sck_en) begin
      p4.o[P4_SCKX]  = EXT_SERIAL_REQ.sck_o;
      p4.oe[P4_SCKX] = 1'b1;
    end
  end

  assign PORT4_PINS          = p4;
  assign SERIAL_A_CLOCK_IN   = PORT4_IN[P4_SCKA];
  assign EXT_SERIAL_CLOCK_IN = PORT4_IN[P4_SCKX];

  // ----------------------------------------------------------------
  // Port five: always I/O, inputs also fan out to peripherals
  // ----------------------------------------------------------------
  assign PORT5_PINS.o         = PORT5_CTRL.dat;
  assign PORT5_PINS.oe        = PORT5_CTRL.dir;
  assign PORT5_PINS.pu        = BYTE_ZERO;
  assign EXT_SERIAL_RX        = PORT5_IN[P5_RXX];
  assign EXT_IRQ_INPUTS_HI    = PORT5_IN[P5_IRQ_LO +: 4];
  assign CONVERTER_TRIGGER_IN = PORT5_IN[P5_TRIG];
  assign TIMER_EVENT_IN       = PORT5_IN[P5_TIMER];

  // ----------------------------------------------------------------
  // Port six: analog or digital per bit
  // ----------------------------------------------------------------
  assign ANALOG_CONNECT    = ANALOG_SEL;
  assign PORT6_PINS.o      = PORT6_CTRL.dat;
  assign PORT6_PINS.oe     = PORT6_CTRL.dir & ~ANALOG_SEL;
  assign PORT6_PINS.pu     = BYTE_ZERO;
  assign PORT6_DIGITAL_IN  = PORT6_IN & ~ANALOG_SEL;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_port0_bus: assert property (@(posedge MCLK) disable iff (!NRST)
    (EXT_BUS_EN && !(settling && !RST_PIN)) |-> (PORT0_PINS.o == BUS_AD_O[7:0]))
    else $error("port zero not carrying low bus byte");
  a_port1_bus: assert property (@(posedge MCLK) disable iff (!NRST)
    (EXT_BUS_EN && !(settling && !RST_PIN)) |-> (PORT1_PINS.o == BUS_AD_O[15:8]))
    else $error("port one not carrying high bus byte");
  a_port2_addr: assert property (@(posedge MCLK) disable iff (!NRST)
    (EXT_BUS_EN && !UPPER_ADDR_OUTPUT_CTRL[0]) |-> (PORT2_PINS.oe[0] && PORT2_PINS.o[0] == UPPER_ADDRESS_LINES[0]))
    else $error("port two bit not driving upper address");
  a_strobe_ale: assert property (@(posedge MCLK) disable iff (!NRST)
    EXT_BUS_EN |-> (PORT3_PINS.o[P3_ALE] == BUS_ALE && PORT3_PINS.oe[P3_ALE]))
    else $error("latch enable not on pin");
  a_strobe_rd: assert property (@(posedge MCLK) disable iff (!NRST)
    EXT_BUS_EN |-> (PORT3_PINS.o[P3_RD] == BUS_RD))
    else $error("read strobe not on pin");
  a_strobe_wr: assert property (@(posedge MCLK) disable iff (!NRST)
    !WR_PIN_EN |-> (PORT3_PINS.oe[P3_WR] == PORT3_CTRL.dir[P3_WR]))
    else $error("write strobe pin taken while disabled");
  a_wr_width: assert property (@(posedge MCLK) disable iff (!NRST)
    !(WR_LOW_BYTE_STROBE && WR_BYTE_STROBE))
    else $error("both write strobe widths active");
  a_serial_tx: assert property (@(posedge MCLK) disable iff (!NRST)
    SERIAL_A_REQ.tx_en |-> (PORT4_PINS.o[P4_TXA] == SERIAL_A_REQ.tx_o))
    else $error("serial A data not on pin");
  a_analog_off: assert property (@(posedge MCLK) disable iff (!NRST)
    ANALOG_SEL[0] |-> !PORT6_PINS.oe[0])
    else $error("analog pin driven digitally");
  a_float_rst: assert property (@(posedge MCLK) disable iff (!NRST)
    (SETTLING && !RST_PIN) |-> (PORT0_PINS.oe == BYTE_ZERO && PORT1_PINS.oe == BYTE_ZERO))
    else $error("ports zero/one driven while reset low");
  a_por_len: assert property (@(posedge MCLK) disable iff (!NRST)
    $rose(INTERNAL_RESET_N) |-> $past(cnt_r) == POR_END)
    else $error("internal reset released early");
  a_settle_len: assert property (@(posedge MCLK) disable iff (!NRST)
    $fell(SETTLING) |-> $past(cnt_r) == SETTLE_END)
    else $error("settling ended at wrong count");
  // Serial pin takeover, input fan-out and idle routing
  a_serial_clk: assert property (@(posedge MCLK) disable iff (!NRST)
    SERIAL_A_REQ.sck_en |-> (PORT4_PINS.oe[P4_SCKA] && PORT4_PINS.o[P4_SCKA] == SERIAL_A_REQ.sck_o))
    else $error("serial A clock not on pin");
  a_ext_tx: assert property (@(posedge MCLK) disable iff (!NRST)
    EXT_SERIAL_REQ.tx_en |-> (PORT4_PINS.oe[P4_TXX] && PORT4_PINS.o[P4_TXX] == EXT_SERIAL_REQ.tx_o))
    else $error("extended serial data not on pin");
  a_ext_clk: assert property (@(posedge MCLK) disable iff (!NRST)
    EXT_SERIAL_REQ.sck_en |-> (PORT4_PINS.oe[P4_SCKX] && PORT4_PINS.o[P4_SCKX] == EXT_SERIAL_REQ.sck_o))
    else $error("extended serial clock not on pin");
  a_ext_rx: assert property (@(posedge MCLK) disable iff (!NRST)
    (EXT_SERIAL_RX == PORT5_IN[P5_RXX]) && (PORT5_PINS.oe == PORT5_CTRL.dir))
    else $error("serial input not fanned out");
  a_irq_fanout: assert property (@(posedge MCLK) disable iff (!NRST)
    EXT_IRQ_INPUTS_HI == PORT5_IN[P5_IRQ_LO +: 4])
    else $error("interrupt inputs not fanned out");
  a_trig_fanout: assert property (@(posedge MCLK) disable iff (!NRST)
    CONVERTER_TRIGGER_IN == PORT5_IN[P5_TRIG])
    else $error("converter trigger not fanned out");
  a_timer_fanout: assert property (@(posedge MCLK) disable iff (!NRST)
    TIMER_EVENT_IN == PORT5_IN[P5_TIMER])
    else $error("timer event not fanned out");
  a_analog_dig: assert property (@(posedge MCLK) disable iff (!NRST)
    ANALOG_SEL[0] |-> !PORT6_DIGITAL_IN[0])
    else $error("analog pin seen as digital");
  a_gpio_idle: assert property (@(posedge MCLK) disable iff (!NRST)
    (!EXT_BUS_EN && !(settling && !RST_PIN)) |-> (PORT0_PINS.o == PORT0_CTRL.dat && PORT0_PINS.oe == PORT0_CTRL.dir))
    else $error("idle port zero not following its registers");
  a_wr_gate: assert property (@(posedge MCLK) disable iff (!NRST)
    !(EXT_BUS_EN && WR_PIN_EN) |-> !(WR_LOW_BYTE_STROBE || WR_BYTE_STROBE))
    else $error("write strobe active while pin disabled");
  a_port3_idle: assert property (@(posedge MCLK) disable iff (!NRST)
    !EXT_BUS_EN |-> (PORT3_PINS.o[P3_WR] == PORT3_CTRL.dat[P3_WR]))
    else $error("write strobe pin taken in single-chip mode");

  c_bus_mode: cover property (@(posedge MCLK) disable iff (!NRST) EXT_BUS_EN && WR_PIN_EN && BUS_WR);
  c_run: cover property (@(posedge MCLK) disable iff (!NRST) $fell(SETTLING));
  c_analog: cover property (@(posedge MCLK) disable iff (!NRST) ANALOG_SEL != BYTE_ZERO);
  c_float: cover property (@(posedge MCLK) disable iff (!NRST) SETTLING && !RST_PIN);
  c_serial: cover property (@(posedge MCLK) disable iff (!NRST) SERIAL_A_REQ.sck_en && EXT_SERIAL_REQ.sck_en);

endmodule : port_pin_function_mux

/* File: test/board_model.sv */
// Board-side model: external pin loads and drive patterns behind the multiplexed pins.
// Assumes per-bit resolution: the mux drives, a pull-up holds high, or the board drives its pattern.
module board_model
  import pin_mux_pkg::*;
(
  input  pin_drive_t pd     [7],
  input  logic [7:0] ext    [7],
  output logic [7:0] pin_in [7]
);
  timeunit 1ns;
  timeprecision 100ps;
  // A released pin never keeps the mux value: pull-up or board pattern
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      pin_in[p] = (pd[p].oe & pd[p].o) | (~pd[p].oe & (pd[p].pu | ext[p]));
    end
  end
endmodule : board_model

/* File: test/port_pin_function_mux_tb.sv */
// Self-checking bench for the port pin function multiplexer.
// Assumes shortened power-on counts and the board model on ports zero to six.
module port_pin_function_mux_tb
  import pin_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int POR_T = 8;
  localparam int SET_T = 16;
  logic        mclk = 1'b0, nrst = 1'b0, rst_pin = 1'b0, bus_en = 1'b0, wr_en = 1'b0, wide = 1'b0;
  logic        ad_oe = 1'b0, ale = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0]  up_ctrl = 8'h00, an_sel = 8'h00, up_addr = 8'h00;
  logic [15:0] ad_o = 16'h0000;
  serial_req_t ser_a = '0, ser_x = '0;
  port_ctrl_t  pc [7];
  logic [7:0]  ext [7];
  pin_drive_t  pd [7];
  logic [7:0]  pin_in [7];
  logic [7:0]  an_conn, p6_dig;
  logic [15:0] ad_i;
  logic [3:0]  irq_hi;
  logic        wr_lo, wr_byte, sck_a_in, sck_x_in, rx_x, trig, tmr, irst_n, settling;
  int          n_mismatch = 0, comparisons = 0, cycles = 0;

  port_pin_function_mux #(.POR_LEN(POR_T), .SETTLE_LEN(SET_T)) i_port_pin_function_mux (
    .MCLK(mclk), .NRST(nrst), .RST_PIN(rst_pin), .EXT_BUS_EN(bus_en), .WR_PIN_EN(wr_en), .BUS_WIDE(wide),
    .UPPER_ADDR_OUTPUT_CTRL(up_ctrl), .ANALOG_SEL(an_sel), .BUS_AD_O(ad_o), .BUS_AD_OE(ad_oe),
    .UPPER_ADDRESS_LINES(up_addr), .BUS_ALE(ale), .BUS_RD(rd), .BUS_WR(wr), .SERIAL_A_REQ(ser_a),
    .EXT_SERIAL_REQ(ser_x), .PORT0_CTRL(pc[0]), .PORT1_CTRL(pc[1]), .PORT2_CTRL(pc[2]), .PORT3_CTRL(pc[3]),
    .PORT4_CTRL(pc[4]), .PORT5_CTRL(pc[5]), .PORT6_CTRL(pc[6]), .PORT0_IN(pin_in[0]), .PORT1_IN(pin_in[1]),
    .PORT4_IN(pin_in[4]), .PORT5_IN(pin_in[5]), .PORT6_IN(pin_in[6]), .PORT0_PINS(pd[0]), .PORT1_PINS(pd[1]),
    .PORT2_PINS(pd[2]), .PORT3_PINS(pd[3]), .PORT4_PINS(pd[4]), .PORT5_PINS(pd[5]), .PORT6_PINS(pd[6]),
    .ANALOG_CONNECT(an_conn), .PORT6_DIGITAL_IN(p6_dig), .BUS_AD_I(ad_i), .WR_LOW_BYTE_STROBE(wr_lo),
    .WR_BYTE_STROBE(wr_byte), .SERIAL_A_CLOCK_IN(sck_a_in), .EXT_SERIAL_CLOCK_IN(sck_x_in),
    .EXT_SERIAL_RX(rx_x), .EXT_IRQ_INPUTS_HI(irq_hi), .CONVERTER_TRIGGER_IN(trig), .TIMER_EVENT_IN(tmr),
    .INTERNAL_RESET_N(irst_n), .SETTLING(settling)
  );
  board_model i_board_model (.pd(pd), .ext(ext), .pin_in(pin_in));

  always #25 mclk = ~mclk;

  // Cuts a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // ----
  // Scenarios
  // ----
  task t_power(input logic pin_lvl);
    int n;
    int por_n;
    n = 0;
    por_n = 0;
    @(posedge mclk);
    nrst <= 1'b0;
    rst_pin <= pin_lvl;
    bus_en <= 1'b1;
    ad_oe <= 1'b1;
    ad_o <= 16'hc35a;
    repeat (16) @(posedge mclk);
    #1 check({irst_n, settling}, 2'b01);
    @(posedge mclk);
    nrst <= 1'b1;
    do begin
      @(posedge mclk);
      #1 n++;
      if (irst_n === 1'b1 && por_n == 0) por_n = n;
      if (settling === 1'b1) check({pd[0].oe, pd[0].pu, pd[1].oe, pd[1].pu}, pin_lvl ? 32'hff00ff00 : 32'h0);
    end while (settling !== 1'b0 && n < 64);
    check(por_n, POR_T);
    check(n, SET_T);
    check({pd[1].o, pd[0].o, pd[1].oe, pd[0].oe}, 32'hc35affff);
  endtask : t_power

  task t_single;
    @(posedge mclk);
    bus_en <= 1'b0;
    wr_en <= 1'b1;
    {ale, rd, wr} <= 3'b111;
    @(negedge mclk);
    for (int p = 0; p < 7; p++) begin
      check(pd[p], {pc[p]} & (p < 4 ? 24'hffffff : 24'hffff00));
    end
  endtask : t_single

  task t_bus;
    @(posedge mclk);
    bus_en <= 1'b1;
    up_ctrl <= 8'h5a;
    up_addr <= 8'hf0;
    {ale, rd, wr, wr_en, wide} <= 5'b10111;
    @(negedge mclk);
    check(pd[0], {8'h5a, 8'hff, 8'h00});
    check(pd[1], {8'hc3, 8'hff, 8'h00});
    check(ad_i, 16'hc35a);
    check(pd[2], {(8'h5a & pc[2].dat) | 8'ha0, (8'h5a & pc[2].dir) | 8'ha5, 8'h5a & pc[2].pull});
    check(pd[3], {pc[3].dat[7:3], 3'b101, pc[3].dir[7:3], 3'b111, pc[3].pull[7:3], 3'b000});
    check({wr_lo, wr_byte}, 2'b10);
    @(posedge mclk);
    {ale, rd, wr, wr_en, wide} <= 5'b01100;
    ad_oe <= 1'b0;
    @(negedge mclk);
    check(pd[3], {pc[3].dat[7:2], 2'b10, pc[3].dir[7:2], 2'b11, pc[3].pull[7:2], 2'b00});
    check({wr_lo, wr_byte}, 2'b00);
    check({pd[1].oe, pd[0].oe}, 16'h0000);
    check(ad_i, {ext[1], ext[0]});
    @(posedge mclk);
    wr_en <= 1'b1;
    @(negedge mclk);
    check(pd[3], {pc[3].dat[7:3], 3'b110, pc[3].dir[7:3], 3'b111, pc[3].pull[7:3], 3'b000});
    check({wr_lo, wr_byte}, 2'b01);
  endtask : t_bus

  task t_serial;
    @(posedge mclk);
    ser_a <= 4'b1110;
    ser_x <= 4'b1011;
    @(negedge mclk);
    check({pd[4].o[7:4], pd[4].oe[7:4], pd[4].pu}, {4'b0101, 4'hf, 8'h00});
    check({pd[4].o[3:0], pd[4].oe[3:0]}, {pc[4].dat[3:0], pc[4].dir[3:0]});
    check({sck_x_in, sck_a_in}, 2'b01);
    @(posedge mclk);
    ser_a <= 4'b0101;
    ser_x <= 4'b0101;
    @(negedge mclk);
    check(pd[4], {pc[4].dat, pc[4].dir, 8'h00});
    check({sck_x_in, sck_a_in}, {pin_in[4][7], pin_in[4][4]});
  endtask : t_serial

  task t_inputs;
    @(posedge mclk);
    pc[5].dir <= 8'h80;
    ext[5] <= 8'h2b;
    @(negedge mclk);
    check({tmr, trig, irq_hi, rx_x}, 7'h2b);
    check(pd[5], {pc[5].dat, 8'h80, 8'h00});
    @(posedge mclk);
    ext[5] <= 8'h54;
    @(negedge mclk);
    check({tmr, trig, irq_hi, rx_x}, 7'h54);
  endtask : t_inputs

  task t_analog;
    logic [7:0] sel;
    for (int k = 0; k < 2; k++) begin
      sel = k ? 8'hf0 : 8'h0f;
      @(posedge mclk);
      an_sel <= sel;
      pc[6].dir <= 8'hff;
      @(negedge mclk);
      check(an_conn, sel);
      check(pd[6].oe, 8'(~sel));
      check(p6_dig, pin_in[6] & sel ^ pin_in[6]);
    end
  endtask : t_analog

  initial begin
    for (int p = 0; p < 7; p++) begin
      pc[p] = {8'h96 ^ 8'(p * 17), 8'h5a ^ 8'(p * 3), 8'h0f ^ 8'(p * 9)};
      ext[p] = 8'h69 ^ 8'(p * 5);
    end
    t_power(1'b0);
    t_single;
    t_bus;
    t_serial;
    t_inputs;
    t_analog;
    t_power(1'b1);
    results;
  end
endmodule : port_pin_function_mux_tb
